// [rtl/wdr_pkg.sv]
// constants and types shared by the watchdog and reset-control block
package wdr_pkg;

   // ----------------------------------------
   // watchdog counter
   // ----------------------------------------
   localparam int COUNT_W = 18;
   localparam logic [COUNT_W-1:0] LIMIT_SLOW_SHORT = 18'h00020;  // 2^5 ticks of 1 kHz
   localparam logic [COUNT_W-1:0] LIMIT_SLOW_LONG = 18'h00100;   // 2^8 ticks of 1 kHz
   localparam logic [COUNT_W-1:0] LIMIT_BUS_SHORT = 18'h02000;   // 2^13 bus cycles
   localparam logic [COUNT_W-1:0] LIMIT_BUS_LONG = 18'h3ffff;    // 2^18 bus cycles, see below
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 18'h00000;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 18'h00001;

   // ----------------------------------------
   // option defaults after any reset
   // ----------------------------------------
   localparam logic ENABLE_RESET = 1'h1;
   localparam logic CLOCK_SEL_RESET = 1'h1;     // bus clock
   localparam logic TIMEOUT_SEL_RESET = 1'h1;   // long timeout
   localparam logic CLOCK_SEL_SLOW = 1'h0;      // internal 1 kHz source

   // ----------------------------------------
   // reset source record layout
   // ----------------------------------------
   localparam int SRC_W = 8;
   localparam int SRC_POWER_ON = 7;
   localparam int SRC_PIN = 6;
   localparam int SRC_WATCHDOG = 5;
   localparam int SRC_ILLEGAL_OPCODE = 4;
   localparam int SRC_ILLEGAL_ADDR = 3;
   localparam int SRC_CLOCK_LOSS = 2;
   localparam int SRC_LOW_VOLTAGE = 1;
   localparam logic [SRC_W-1:0] SRC_NONE = 8'h00;
   localparam logic [SRC_W-1:0] SRC_RESET = 8'h80;   // power-on bit only

   // ----------------------------------------
   // reset sequencing and cpu initial state
   // ----------------------------------------
   localparam int HOLD_W = 4;
   localparam logic [HOLD_W-1:0] HOLD_CYCLES = 4'h8;
   localparam logic [HOLD_W-1:0] HOLD_ZERO = 4'h0;
   localparam logic [HOLD_W-1:0] HOLD_ONE = 4'h1;
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
   localparam logic [15:0] STACK_POINTER_INIT = 16'h00ff;

   typedef enum logic {
      ST_HOLD,
      ST_RUN
   } wdr_state_t;

   // picks the overflow value for a clock/timeout selection
   function automatic logic [COUNT_W-1:0] wdr_limit(input logic clock_sel,
                                                    input logic timeout_sel);
      logic [COUNT_W-1:0] lim;
      lim = LIMIT_BUS_LONG;
      unique case ({clock_sel, timeout_sel})
         2'h0: lim = LIMIT_SLOW_SHORT;
         2'h1: lim = LIMIT_SLOW_LONG;
         2'h2: lim = LIMIT_BUS_SHORT;
         2'h3: lim = LIMIT_BUS_LONG;
      endcase
      return lim;
   endfunction

endpackage

// [rtl/wdr_counter.sv]
// watchdog up-counter with clear, advance and overflow compare
`timescale 1ns/10ps
module wdr_counter (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic clear_i,
   input wire logic advance_i,
   input wire logic [wdr_pkg::COUNT_W-1:0] limit_i,
   output logic [wdr_pkg::COUNT_W-1:0] count_o,
   output logic hit_o
);
   import wdr_pkg::*;

   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] next_count;

   // ----------------------------------------
   // next count
   // ----------------------------------------
   always_comb begin
      next_count = count;
      if (clear_i) begin
         next_count = COUNT_ZERO;
      end else if (advance_i && (count != limit_i)) begin
         // parks at the limit so one overflow never wraps into a second
         next_count = count + COUNT_ONE;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count <= COUNT_ZERO;
      end else if (clk_en_i) begin
         count <= next_count;
      end
   end

   assign count_o = count;
   assign hit_o = (count == limit_i);

endmodule

// [rtl/wdr_watchdog_reset.sv]
// watchdog timer, write-once options, reset sequencing and reset source record
//
// Overview of operation
// - any reset sets the watchdog enable, so it runs by default.
// - with enable cleared the watchdog never produces a timeout reset.
// - any write to the reset-source address clears the watchdog counter.
// - reset-source record is read-only; service writes leave it unchanged.
// - clock select zero picks the 1 kHz tick, one picks the bus clock.
// - timeout select picks 2^5/2^8 ticks or 2^13/2^18 bus cycles.
// - after reset, defaults are bus clock with long timeout.
// - reaching the overflow count unserviced forces a system reset.
// - both option registers are write-once; the first write clears the counter.
// - counter holds its value in background debug mode.
// - bus clock selected: counter freezes in stop, resumes after it.
// - 1 kHz selected: counter cleared on stop entry, restarts from zero.
// - record the last reset source; debug-forced reset has no bit.
// - on reset, load pc from 0xfffe, sp to 0x00ff, set interrupt mask.
// - during reset, peripherals off, pins hi-z inputs, pull-ups off.
`timescale 1ns/10ps
module wdr_watchdog_reset (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic tick_1khz_i,
   input wire logic stop_mode_i,
   input wire logic debug_mode_i,
   input wire logic service_wr_i,
   input wire logic options_a_wr_i,
   input wire logic options_a_enable_i,
   input wire logic options_a_timeout_i,
   input wire logic options_b_wr_i,
   input wire logic options_b_clock_i,
   input wire logic pin_reset_i,
   input wire logic low_voltage_reset_i,
   input wire logic illegal_opcode_i,
   input wire logic illegal_addr_i,
   input wire logic clock_loss_i,
   input wire logic debug_reset_i,
   output logic wdog_enable_o,
   output logic wdog_clock_select_o,
   output logic wdog_timeout_select_o,
   output logic system_options_a_locked_o,
   output logic system_options_b_locked_o,
   output logic [wdr_pkg::SRC_W-1:0] reset_source_register_o,
   output logic [wdr_pkg::COUNT_W-1:0] wdog_count_o,
   output logic system_reset_o,
   output logic pc_load_o,
   output logic [15:0] reset_vector_addr_o,
   output logic [15:0] stack_pointer_init_o,
   output logic int_mask_set_o,
   output logic peripheral_disable_o,
   output logic pins_hiz_no_pullup_o
);
   import wdr_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   wdr_state_t state;
   wdr_state_t next_state;
   logic [HOLD_W-1:0] hold_count;
   logic [HOLD_W-1:0] next_hold_count;
   logic [SRC_W-1:0] reset_source;
   logic [SRC_W-1:0] next_reset_source;
   logic wdog_enable;
   logic next_wdog_enable;
   logic wdog_clock_select;
   logic next_wdog_clock_select;
   logic wdog_timeout_select;
   logic next_wdog_timeout_select;
   logic lock_a;
   logic next_lock_a;
   logic lock_b;
   logic next_lock_b;
   logic system_reset;
   logic next_system_reset;

   logic [SRC_W-1:0] req_flags;
   logic wdog_timeout;
   logic any_request;
   logic first_write;
   logic cnt_clear;
   logic cnt_advance;
   logic cnt_hit;
   logic [COUNT_W-1:0] cnt_limit;
   logic [COUNT_W-1:0] cnt_value;

   // ----------------------------------------
   // watchdog counter
   // ----------------------------------------
   assign cnt_limit = wdr_limit(wdog_clock_select, wdog_timeout_select);

   assign first_write = (state == ST_RUN) &&
                        ((options_a_wr_i && !lock_a) || (options_b_wr_i && !lock_b));

   // clearing is the only action of the service write
   assign cnt_clear = (state == ST_HOLD) || any_request ||
                      ((state == ST_RUN) && service_wr_i) ||
                      first_write ||
                      ((wdog_clock_select == CLOCK_SEL_SLOW) && stop_mode_i);

   // slow source: the tick counts only outside stop, from zero after it
   // bus source: stop merely pauses the count
   always_comb begin
      cnt_advance = 1'b0;
      if ((state == ST_RUN) && wdog_enable && !debug_mode_i && !stop_mode_i) begin
         if (wdog_clock_select == CLOCK_SEL_SLOW) begin
            cnt_advance = tick_1khz_i;
         end else begin
            cnt_advance = 1'b1;
         end
      end
   end

   wdr_counter u_counter (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .clk_en_i(clk_en_i),
      .clear_i(cnt_clear),
      .advance_i(cnt_advance),
      .limit_i(cnt_limit),
      .count_o(cnt_value),
      .hit_o(cnt_hit)
   );

   // the long bus limit is one short of 2^18 in an 18-bit counter, so the
   // hit is taken on the advance that would carry out of bit 17
   always_comb begin
      wdog_timeout = 1'b0;
      if ((state == ST_RUN) && wdog_enable) begin
         if (cnt_limit == LIMIT_BUS_LONG) begin
            wdog_timeout = cnt_hit && cnt_advance;
         end else begin
            wdog_timeout = cnt_hit;
         end
      end
   end

   // ----------------------------------------
   // reset requests
   // ----------------------------------------
   // debug-forced reset has no bit of its own
   always_comb begin
      req_flags = SRC_NONE;
      req_flags[SRC_PIN] = pin_reset_i;
      req_flags[SRC_WATCHDOG] = wdog_timeout;
      req_flags[SRC_ILLEGAL_OPCODE] = illegal_opcode_i;
      req_flags[SRC_ILLEGAL_ADDR] = illegal_addr_i;
      req_flags[SRC_CLOCK_LOSS] = clock_loss_i;
      req_flags[SRC_LOW_VOLTAGE] = low_voltage_reset_i;
   end

   assign any_request = (|req_flags) || debug_reset_i;

   // ----------------------------------------
   // sequencer and option registers
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_hold_count = hold_count;
      next_reset_source = reset_source;
      next_wdog_enable = wdog_enable;
      next_wdog_clock_select = wdog_clock_select;
      next_wdog_timeout_select = wdog_timeout_select;
      next_lock_a = lock_a;
      next_lock_b = lock_b;
      next_system_reset = system_reset;
      unique case (state)
         ST_RUN: begin
            if (any_request) begin
               next_state = ST_HOLD;
               next_hold_count = HOLD_CYCLES;
               next_reset_source = req_flags;
               next_system_reset = 1'b1;
               next_wdog_enable = ENABLE_RESET;
               next_wdog_clock_select = CLOCK_SEL_RESET;
               next_wdog_timeout_select = TIMEOUT_SEL_RESET;
               next_lock_a = 1'b0;
               next_lock_b = 1'b0;
            end else begin
               // a service write has no path into the record
               if (options_a_wr_i && !lock_a) begin
                  next_wdog_enable = options_a_enable_i;
                  next_wdog_timeout_select = options_a_timeout_i;
                  next_lock_a = 1'b1;
               end
               if (options_b_wr_i && !lock_b) begin
                  next_wdog_clock_select = options_b_clock_i;
                  next_lock_b = 1'b1;
               end
            end
         end
         ST_HOLD: begin
            // a source still asserted keeps the system in reset
            if (any_request) begin
               next_hold_count = HOLD_CYCLES;
               next_reset_source = reset_source | req_flags;
            end else if (hold_count == HOLD_ZERO) begin
               next_state = ST_RUN;
               next_system_reset = 1'b0;
            end else begin
               next_hold_count = hold_count - HOLD_ONE;
            end
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= ST_HOLD;
         hold_count <= HOLD_CYCLES;
         reset_source <= SRC_RESET;
         wdog_enable <= ENABLE_RESET;
         wdog_clock_select <= CLOCK_SEL_RESET;
         wdog_timeout_select <= TIMEOUT_SEL_RESET;
         lock_a <= 1'b0;
         lock_b <= 1'b0;
         system_reset <= 1'b1;
      end else if (clk_en_i) begin
         state <= next_state;
         hold_count <= next_hold_count;
         reset_source <= next_reset_source;
         wdog_enable <= next_wdog_enable;
         wdog_clock_select <= next_wdog_clock_select;
         wdog_timeout_select <= next_wdog_timeout_select;
         lock_a <= next_lock_a;
         lock_b <= next_lock_b;
         system_reset <= next_system_reset;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign wdog_enable_o = wdog_enable;
   assign wdog_clock_select_o = wdog_clock_select;
   assign wdog_timeout_select_o = wdog_timeout_select;
   assign system_options_a_locked_o = lock_a;
   assign system_options_b_locked_o = lock_b;
   assign reset_source_register_o = reset_source;
   assign wdog_count_o = cnt_value;
   assign system_reset_o = system_reset;

   // cpu initial conditions, applied for the whole reset hold
   assign pc_load_o = system_reset;
   assign reset_vector_addr_o = RESET_VECTOR_ADDR;
   assign stack_pointer_init_o = STACK_POINTER_INIT;
   assign int_mask_set_o = system_reset;
   assign peripheral_disable_o = system_reset;
   assign pins_hiz_no_pullup_o = system_reset;

endmodule

// [bench/wdr_checker_assertions.sv]
// port-level assertions for the watchdog and reset-control block
`timescale 1ns/10ps
module wdr_checker (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic tick_1khz_i,
   input wire logic stop_mode_i,
   input wire logic debug_mode_i,
   input wire logic service_wr_i,
   input wire logic options_a_wr_i,
   input wire logic options_b_wr_i,
   input wire logic pin_reset_i,
   input wire logic low_voltage_reset_i,
   input wire logic illegal_opcode_i,
   input wire logic illegal_addr_i,
   input wire logic clock_loss_i,
   input wire logic debug_reset_i,
   input wire logic wdog_enable_o,
   input wire logic wdog_clock_select_o,
   input wire logic wdog_timeout_select_o,
   input wire logic system_options_a_locked_o,
   input wire logic [wdr_pkg::SRC_W-1:0] reset_source_register_o,
   input wire logic [wdr_pkg::COUNT_W-1:0] wdog_count_o,
   input wire logic system_reset_o,
   input wire logic pc_load_o,
   input wire logic peripheral_disable_o,
   input wire logic int_mask_set_o,
   input wire logic pins_hiz_no_pullup_o
);
   import wdr_pkg::*;
   // ------
   // helpers
   // ------
   logic [COUNT_W-1:0] lim;
   logic rq;
   logic q;
   logic run;
   logic adv;
   assign lim = wdr_limit(wdog_clock_select_o, wdog_timeout_select_o);
   assign rq = pin_reset_i | low_voltage_reset_i | illegal_opcode_i | illegal_addr_i
      | clock_loss_i | debug_reset_i;
   // quiet: no write, no request, out of reset
   assign q = clk_en_i & ~rq & ~system_reset_o & ~service_wr_i & ~options_a_wr_i
      & ~options_b_wr_i;
   assign run = q & wdog_enable_o & ~debug_mode_i & ~stop_mode_i;
   assign adv = wdog_clock_select_o | tick_1khz_i;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   AST_SERVICE: assert property (
      service_wr_i && clk_en_i && !system_reset_o |=> wdog_count_o == COUNT_ZERO)
      else $error("service did not clear count");
   AST_SRC_KEEP: assert property (
      service_wr_i && clk_en_i && !rq && !system_reset_o && wdog_count_o != lim
      |=> $stable(reset_source_register_o))
      else $error("service changed source record");
   AST_DEBUG_HOLD: assert property (
      q && debug_mode_i && !stop_mode_i && wdog_count_o != lim |=> $stable(wdog_count_o))
      else $error("count moved in debug");
   AST_BUS_STOP: assert property (
      q && stop_mode_i && wdog_clock_select_o && wdog_count_o != lim
      |=> $stable(wdog_count_o))
      else $error("count moved in stop");
   AST_SLOW_STOP: assert property (
      q && stop_mode_i && !wdog_clock_select_o |=> wdog_count_o == COUNT_ZERO)
      else $error("slow stop did not zero count");
   AST_DISABLED: assert property (
      q && !wdog_enable_o |=> !system_reset_o)
      else $error("timeout while disabled");
   AST_TIMEOUT: assert property (
      run && wdog_count_o == lim && lim != LIMIT_BUS_LONG
      |=> system_reset_o && reset_source_register_o[SRC_WATCHDOG])
      else $error("no reset at overflow");
   AST_ADVANCE: assert property (
      run && wdog_count_o != lim
      |=> wdog_count_o == $past(wdog_count_o) + {17'h0, $past(adv)})
      else $error("count advance wrong");
   AST_DEFAULTS: assert property (
      $rose(system_reset_o) |-> wdog_enable_o && wdog_clock_select_o
      && wdog_timeout_select_o && !system_options_a_locked_o && wdog_count_o == COUNT_ZERO)
      else $error("defaults not forced by reset");
   AST_RESET_OUTS: assert property (
      pc_load_o == system_reset_o && peripheral_disable_o == system_reset_o
      && int_mask_set_o == system_reset_o && pins_hiz_no_pullup_o == system_reset_o)
      else $error("reset side outputs wrong");
   AST_CLK_EN_HOLD: assert property (
      !clk_en_i |=> $stable(wdog_count_o) && $stable(system_reset_o)
      && $stable(reset_source_register_o) && $stable(wdog_enable_o))
      else $error("state moved with clock enable low");
endmodule
bind wdr_watchdog_reset wdr_checker chk (.*);

// [bench/tb.sv]
// self-checking testbench for the watchdog and reset-control block
`timescale 1ns/10ps
module tb;
   import wdr_pkg::*;
   logic clock_i, resetn_i, clk_en_i, tick_1khz_i, stop_mode_i, debug_mode_i, service_wr_i;
   logic options_a_wr_i, options_a_enable_i, options_a_timeout_i, options_b_wr_i;
   logic options_b_clock_i, pin_reset_i, low_voltage_reset_i, illegal_opcode_i;
   logic illegal_addr_i, clock_loss_i, debug_reset_i;
   logic wdog_enable_o, wdog_clock_select_o, wdog_timeout_select_o;
   logic system_options_a_locked_o, system_options_b_locked_o;
   logic [SRC_W-1:0] reset_source_register_o;
   logic [COUNT_W-1:0] wdog_count_o;
   logic system_reset_o, pc_load_o, int_mask_set_o, peripheral_disable_o, pins_hiz_no_pullup_o;
   logic [15:0] reset_vector_addr_o, stack_pointer_init_o;
   logic [5:0] req;
   logic [7:0] srcs [6] = '{8'h40, 8'h02, 8'h10, 8'h08, 8'h04, 8'h00};
   int miscompares, tests_run, n;
   assign {debug_reset_i, clock_loss_i, illegal_addr_i, illegal_opcode_i,
      low_voltage_reset_i, pin_reset_i} = req;
   wdr_watchdog_reset dut (.*);
   // ------
   // tasks
   // ------
   task automatic cyc(input int k);
      repeat (k) @(posedge clock_i);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // bounded wait, leaves the cycle count in n
   task automatic until_rst(input logic lvl, input int lim);
      n = 0;
      do begin
         cyc(1);
         #1 n++;
      end while (system_reset_o !== lvl && n < lim);
   endtask
   task automatic ticks(input int k);
      repeat (k) begin
         cyc(1);
         tick_1khz_i <= 1;
         cyc(1);
         tick_1khz_i <= 0;
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      clock_i = 0;
      forever #5 clock_i = ~clock_i;
   end
   // run needs about 18k cycles
   initial begin
      #300000;
      miscompares++;
      print_verdict();
   end
   // ------
   // tests
   // ------
   initial begin
      {resetn_i, tick_1khz_i, stop_mode_i, debug_mode_i, service_wr_i} = 0;
      {options_a_wr_i, options_a_enable_i, options_a_timeout_i} = 0;
      {options_b_wr_i, options_b_clock_i, req} = 0;
      clk_en_i = 1;
      cyc(3);
      #1 chk({system_reset_o, peripheral_disable_o, pins_hiz_no_pullup_o}, 3'h7);
      chk({pc_load_o, int_mask_set_o}, 2'h3);
      cyc(1);
      resetn_i <= 1;
      until_rst(0, 50);
      chk(wdog_enable_o, 1);
      chk({wdog_clock_select_o, wdog_timeout_select_o}, 2'h3);
      chk(reset_source_register_o, 8'h80);
      chk({reset_vector_addr_o, stack_pointer_init_o}, 32'hfffe00ff);
      chk({pc_load_o, int_mask_set_o, peripheral_disable_o, pins_hiz_no_pullup_o}, 0);
      cyc(1);
      service_wr_i <= 1; // serviced from the main sequence only
      cyc(1);
      service_wr_i <= 0;
      cyc(4);
      debug_mode_i <= 1;
      cyc(6);
      debug_mode_i <= 0;
      stop_mode_i <= 1;
      cyc(6);
      stop_mode_i <= 0;
      #1 chk(wdog_count_o, 4);
      chk(reset_source_register_o, 8'h80);
      cyc(3);
      #1 chk(wdog_count_o, 7);
      // clock enable low: count frozen and the service pulse ignored
      cyc(1);
      clk_en_i <= 0;
      service_wr_i <= 1;
      cyc(4);
      clk_en_i <= 1;
      service_wr_i <= 0;
      #1 chk(wdog_count_o, 8);
      cyc(1);
      {options_a_wr_i, options_b_wr_i, options_a_enable_i, options_b_clock_i} <= 4'hf;
      cyc(1);
      {options_a_enable_i, options_b_clock_i} <= 2'h0;
      cyc(1);
      {options_a_wr_i, options_b_wr_i} <= 2'h0;
      #1 chk({wdog_enable_o, wdog_timeout_select_o, wdog_clock_select_o}, 3'h5);
      chk({system_options_a_locked_o, system_options_b_locked_o}, 2'h3);
      until_rst(1, 9000);
      chk(n, 8192);
      chk(reset_source_register_o, 8'h20);
      until_rst(0, 50);
      chk({wdog_enable_o, wdog_clock_select_o, wdog_timeout_select_o}, 3'h7);
      chk({system_options_a_locked_o, system_options_b_locked_o}, 2'h0);
      cyc(1);
      options_a_wr_i <= 1;
      cyc(1);
      options_a_wr_i <= 0;
      until_rst(1, 9000);
      chk({system_reset_o, wdog_count_o}, 0);
      for (int i = 0; i < 6; i++) begin
         cyc(1);
         req <= 6'h01 << i;
         cyc(1);
         req <= 6'h00;
         until_rst(0, 50);
         chk(reset_source_register_o, srcs[i]);
         chk(wdog_enable_o, 1);
      end
      cyc(1);
      {options_a_wr_i, options_a_enable_i, options_b_wr_i} <= 3'h7;
      cyc(1);
      {options_a_wr_i, options_b_wr_i} <= 2'h0;
      ticks(31);
      #1 chk({system_reset_o, wdog_count_o}, 31);
      cyc(1);
      stop_mode_i <= 1;
      cyc(2);
      stop_mode_i <= 0;
      #1 chk(wdog_count_o, 0);
      ticks(32);
      cyc(1);
      #1 chk({system_reset_o, reset_source_register_o[SRC_WATCHDOG]}, 2'h3);
      until_rst(0, 50);
      print_verdict();
   end
endmodule
